/* File: mcdma_avm_model.sv */
// Avalon-MM slave standing in for memories and peripheral registers.
// Assumes a master that holds each request until it sees waitrequest low.
`timescale 1ns/100ps

module mcdma_avm_model (
	input  wire logic                      clk,
	input  wire mcdma_pkg::mcdma_avm_req_t req,
	output mcdma_pkg::mcdma_avm_rsp_t      rsp
);
	import mcdma_pkg::*;
	mcdma_avm_rsp_t r = '{32'h0, 1'b1, RESP_OK};
	int             wait_cnt = 0;
	logic [31:0]    waddr;
	assign rsp = r;
	assign waddr = {req.address[31:2], 2'h0};
	// Idle data toggles every cycle so a stale read never looks fresh.
	always @(posedge clk) begin
		if (!r.waitrequest || !(req.read || req.write)) begin
			r.waitrequest <= 1'b1;
			r.readdata <= ~r.readdata;
			r.response <= RESP_OK;
			wait_cnt <= $urandom_range(2, 0);
		end else if (wait_cnt != 0) begin
			wait_cnt <= wait_cnt - 1;
			r.readdata <= ~r.readdata;
		end else begin
			r.waitrequest <= 1'b0;
			r.readdata <= waddr ^ 32'h5a3c_96e1;
			r.response <= (req.read && waddr[31:28] == 4'hf) ? 2'h2 : RESP_OK;
		end
	end
endmodule // mcdma_avm_model

/* File: mcdma_pkg.sv */
// Shared constants, field layouts and carriers of the DMA controller.
// Assumes one system clock; registers reached over Avalon-MM.
package mcdma_pkg;
	localparam int CH_A = 7;
	localparam int CH_B = 5;
	localparam int RPC  = 2;
	localparam int AW   = 11;
	localparam int CW   = 17;
	////////////////////////////////////////////////////////////////////////
	localparam logic [AW-1:0] A_INTF  = 11'h000;
	localparam logic [AW-1:0] A_INTC  = 11'h004;
	localparam logic [6:0]    CH_BLK0 = 7'h01;
	localparam logic [3:0]    O_CTL   = 4'h0;
	localparam logic [3:0]    O_CNT   = 4'h4;
	localparam logic [3:0]    O_PA    = 4'h8;
	localparam logic [3:0]    O_MA    = 4'hc;
	////////////////////////////////////////////////////////////////////////
	localparam int C_EN   = 0;
	localparam int C_FIE  = 1;
	localparam int C_HIE  = 2;
	localparam int C_EIE  = 3;
	localparam int C_DIR  = 4;
	localparam int C_CIRC = 5;
	localparam int C_PINC = 6;
	localparam int C_MINC = 7;
	localparam int C_PSZ  = 8;
	localparam int C_MSZ  = 10;
	localparam int C_PRIO = 12;
	localparam int C_M2M  = 14;
	localparam logic [31:0] CTL_MASK = 32'h0000_7fff;
	localparam int F_FT = 0;
	localparam int F_HT = 1;
	localparam int F_ER = 2;
	localparam logic [1:0] SZ_B = 2'h0;
	localparam logic [1:0] SZ_H = 2'h1;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [31:0]   RST_CTL  = 32'h0;
	localparam logic [31:0]   RST_ADDR = 32'h0;
	localparam logic [CW-1:0] RST_CNT  = 17'h0;
	localparam logic [CW-1:0] CNT_MAX  = 17'h1_0000;
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic          read;
		logic          write;
		logic [AW-1:0] address;
		logic [31:0]   writedata;
	} mcdma_avs_req_t;
	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} mcdma_avs_rsp_t;
	typedef struct packed {
		logic        read;
		logic        write;
		logic [31:0] address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} mcdma_avm_req_t;
	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
		logic [1:0]  response;
	} mcdma_avm_rsp_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RD   = 2'b01,
		ST_WR   = 2'b10
	} mcdma_state_t;
endpackage

/* File: mcdma_top.sv */
// Two DMA controller instances, a shared register engine per instance.
// Assumes Avalon-MM masters and slaves on clk; requests are synchronous.
// Operation
// RULE_01 - Two instances: seven and five channels
// RULE_02 - Item count up to 65536 per run
// RULE_03 - Four-level software priority decides first
// RULE_04 - Equal priority: lower channel number wins
// RULE_05 - Per-side access width 8, 16 or 32
// RULE_06 - Per-side fixed or incrementing address
// RULE_07 - Circular mode restarts finished run
// RULE_08 - Periph-to-mem, mem-to-periph, mem-to-mem directions
// RULE_09 - Per-channel interrupt from three enabled flags
// RULE_10 - One slave port, memory and peripheral masters
// RULE_11 - Arbiter grants exactly one pending channel
// RULE_12 - Channel fed by fixed request inputs
// RULE_13 - Any addressed target may be source/destination
// RULE_14 - Each item: read source, then write destination
// RULE_15 - Items moved equal programmed count
// RULE_16 - Access byte size follows configured widths
// RULE_17 - Wider destination gets zero-filled upper bits
// RULE_18 - Narrower destination keeps only low bits
// RULE_19 - Each side steps by its own size
// RULE_20 - Acknowledge when peripheral access starts
// RULE_21 - Circular reloads count, flags full finish
// RULE_22 - Memory-to-memory runs unrequested, stops at zero
// RULE_23 - Increment by 1, 2, 4; fixed stays
// RULE_24 - Finish read and write before rearbitrating
`timescale 1ns/100ps

module mcdma_core #(
	parameter int NCH = 7
) (
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	input  wire mcdma_pkg::mcdma_avs_req_t   avs_req,
	output mcdma_pkg::mcdma_avs_rsp_t        avs_rsp,
	output mcdma_pkg::mcdma_avm_req_t        mem_req,
	input  wire mcdma_pkg::mcdma_avm_rsp_t   mem_rsp,
	output mcdma_pkg::mcdma_avm_req_t        per_req,
	input  wire mcdma_pkg::mcdma_avm_rsp_t   per_rsp,
	input  wire logic [NCH*mcdma_pkg::RPC-1:0] dreq,
	output logic [NCH*mcdma_pkg::RPC-1:0]    dack,
	output logic [NCH-1:0]                   irq
);
	import mcdma_pkg::*;

	function automatic logic [31:0] sz_bytes(input logic [1:0] s);
		return (s == SZ_B) ? 32'h1 : (s == SZ_H) ? 32'h2 : 32'h4;
	endfunction
	function automatic logic [31:0] wmask(input logic [1:0] s);
		return (s == SZ_B) ? 32'hff : (s == SZ_H) ? 32'hffff
			: 32'hffff_ffff;
	endfunction
	function automatic logic [3:0] lanes(input logic [1:0] a,
		input logic [1:0] s);
		logic [3:0] b;
		b = (s == SZ_B) ? 4'h1 : (s == SZ_H) ? 4'h3 : 4'hf;
		return b << a;
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic [31:0]    ctl_reg  [NCH];
	logic [31:0]    ctl_next [NCH];
	logic [CW-1:0]  cnt_reg  [NCH];
	logic [CW-1:0]  cnt_next [NCH];
	logic [CW-1:0]  rld_reg  [NCH];
	logic [CW-1:0]  rld_next [NCH];
	logic [31:0]    pb_reg   [NCH];
	logic [31:0]    pb_next  [NCH];
	logic [31:0]    mb_reg   [NCH];
	logic [31:0]    mb_next  [NCH];
	logic [31:0]    pc_reg   [NCH];
	logic [31:0]    pc_next  [NCH];
	logic [31:0]    mc_reg   [NCH];
	logic [31:0]    mc_next  [NCH];
	logic [2:0]     fl_reg   [NCH];
	logic [2:0]     fl_next  [NCH];
	mcdma_state_t   st_reg, st_next;
	logic [2:0]     sel_reg, sel_next;
	logic           ack_reg, ack_next;
	mcdma_avs_rsp_t avs_reg, avs_next;
	mcdma_avm_req_t mreq_reg, mreq_next;
	mcdma_avm_req_t preq_reg, preq_next;
	logic [NCH*RPC-1:0] dack_reg, dack_next;
	logic [NCH-1:0] irq_reg, irq_next;

	logic           any_el, sw_wr, src_per, dst_per, rd_ok, wr_ok;
	logic [2:0]     win, ix;
	logic [31:0]    c, src_a, dst_a, rdat;
	logic [1:0]     src_sz, dst_sz, bprio;
	mcdma_avm_rsp_t rsp_rd, rsp_wr;
	mcdma_avm_req_t acc;
	logic [CW-1:0]  cdec;
	logic [6:0]     blk;
	logic [2:0]     wch;
	logic           ch_hit;

	////////////////////////////////////////////////////////////////////////
	// Arbiter: scanning downward with >= lets the lower channel win ties.
	always_comb begin
		any_el = 1'b0;
		win    = 3'h0;
		bprio  = 2'h0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (ctl_reg[i][C_EN] && cnt_reg[i] != RST_CNT &&
				(ctl_reg[i][C_M2M] ||
				|dreq[i*RPC +: RPC])) begin // RULE_12 RULE_22
				if (!any_el || ctl_reg[i][C_PRIO +: 2] >= bprio) begin
					win   = 3'(i); // RULE_03 RULE_04 RULE_11
					bprio = ctl_reg[i][C_PRIO +: 2];
				end
				any_el = 1'b1;
			end
		end
	end

	assign ix      = (st_reg == ST_IDLE) ? win : sel_reg;
	assign c       = ctl_reg[ix];
	// Memory-to-memory keeps both accesses on the memory master.
	assign src_per = !c[C_DIR] && !c[C_M2M]; // RULE_08 RULE_10
	assign dst_per = c[C_DIR] && !c[C_M2M];
	assign src_a   = c[C_DIR] ? mc_reg[ix] : pc_reg[ix];
	assign dst_a   = c[C_DIR] ? pc_reg[ix] : mc_reg[ix];
	assign src_sz  = c[C_DIR] ? c[C_MSZ +: 2] : c[C_PSZ +: 2]; // RULE_05
	assign dst_sz  = c[C_DIR] ? c[C_PSZ +: 2] : c[C_MSZ +: 2];
	assign rsp_rd  = src_per ? per_rsp : mem_rsp;
	assign rsp_wr  = dst_per ? per_rsp : mem_rsp;
	assign rd_ok   = st_reg == ST_RD && !rsp_rd.waitrequest;
	assign wr_ok   = st_reg == ST_WR && !rsp_wr.waitrequest;
	assign rdat    = (rsp_rd.readdata >> {src_a[1:0], 3'b000})
		& wmask(src_sz); // RULE_17
	assign sw_wr   = ack_reg && avs_req.write;
	assign blk     = avs_req.address[AW-1:4];
	assign wch     = 3'(blk - CH_BLK0);
	// Block number is compared untruncated so high addresses never alias.
	assign ch_hit  = blk >= CH_BLK0 && blk < CH_BLK0 + 7'(NCH);
	assign cdec    = cnt_reg[sel_reg] - 17'h1;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		ctl_next  = ctl_reg;
		cnt_next  = cnt_reg;
		rld_next  = rld_reg;
		pb_next   = pb_reg;
		mb_next   = mb_reg;
		pc_next   = pc_reg;
		mc_next   = mc_reg;
		fl_next   = fl_reg;
		st_next   = st_reg;
		sel_next  = sel_reg;
		mreq_next = mreq_reg;
		preq_next = preq_reg;
		dack_next = '0;
		acc       = '0;
		// Clears go first so a same-cycle hardware event survives.
		if (sw_wr && avs_req.address == A_INTC) begin
			for (int i = 0; i < NCH; i++) begin
				if (avs_req.writedata[4*i]) begin
					fl_next[i] = 3'h0;
				end
				for (int f = 0; f < 3; f++) begin
					if (avs_req.writedata[4*i+f+1]) begin
						fl_next[i][f] = 1'b0;
					end
				end
			end
		end
		unique case (st_reg)
			ST_IDLE: begin
				if (any_el) begin
					sel_next       = win;
					st_next        = ST_RD;
					acc.read       = 1'b1; // RULE_14 RULE_13
					acc.address    = {src_a[31:2], 2'b00};
					acc.byteenable = lanes(src_a[1:0], src_sz); // RULE_16
					if (src_per) begin
						preq_next = acc;
					end else begin
						mreq_next = acc;
					end
				end
			end
			ST_RD: begin
				if (rd_ok) begin
					mreq_next.read = 1'b0;
					preq_next.read = 1'b0;
					if (rsp_rd.response != RESP_OK) begin
						fl_next[sel_reg][F_ER] = 1'b1;
						ctl_next[sel_reg][C_EN] = 1'b0;
						st_next = ST_IDLE;
					end else begin
						st_next        = ST_WR;
						acc.write      = 1'b1;
						acc.address    = {dst_a[31:2], 2'b00};
						acc.byteenable = lanes(dst_a[1:0], dst_sz);
						acc.writedata  = (rdat & wmask(dst_sz))
							<< {dst_a[1:0], 3'b000}; // RULE_18
						if (dst_per) begin
							preq_next = acc;
						end else begin
							mreq_next = acc;
						end
					end
				end
			end
			ST_WR: begin
				if (wr_ok) begin
					mreq_next.write = 1'b0;
					preq_next.write = 1'b0;
					st_next = ST_IDLE; // RULE_24
					cnt_next[sel_reg] = cdec; // RULE_15
					if (ctl_reg[sel_reg][C_PINC]) begin
						pc_next[sel_reg] = pc_reg[sel_reg]
							+ sz_bytes(ctl_reg[sel_reg][C_PSZ +: 2]); // RULE_19
					end
					if (ctl_reg[sel_reg][C_MINC]) begin
						mc_next[sel_reg] = mc_reg[sel_reg]
							+ sz_bytes(ctl_reg[sel_reg][C_MSZ +: 2]); // RULE_23
					end
					if (cdec == rld_reg[sel_reg] >> 1) begin
						fl_next[sel_reg][F_HT] = 1'b1;
					end
					if (cdec == RST_CNT) begin
						fl_next[sel_reg][F_FT] = 1'b1; // RULE_21
						if (ctl_reg[sel_reg][C_CIRC]) begin
							cnt_next[sel_reg] = rld_reg[sel_reg]; // RULE_07
							pc_next[sel_reg]  = pb_reg[sel_reg];
							mc_next[sel_reg]  = mb_reg[sel_reg];
						end
					end
				end
			end
			default: begin
				st_next = ST_IDLE;
			end
		endcase
		// Acknowledge the lowest pending line when a peripheral access
		// starts; the peripheral drops its request after it.
		if ((preq_next.read && !preq_reg.read) ||
			(preq_next.write && !preq_reg.write)) begin
			for (int j = RPC - 1; j >= 0; j--) begin
				if (dreq[sel_next*RPC + j]) begin
					dack_next = '0;
					dack_next[sel_next*RPC + j] = 1'b1; // RULE_20
				end
			end
		end
		// Channel register writes land last, so they override the engine.
		if (sw_wr && ch_hit) begin
			unique case (avs_req.address[3:0])
				O_CTL: ctl_next[wch] = avs_req.writedata & CTL_MASK;
				O_CNT: begin
					cnt_next[wch] = (avs_req.writedata > 32'(CNT_MAX))
						? CNT_MAX : avs_req.writedata[CW-1:0]; // RULE_02
					rld_next[wch] = cnt_next[wch];
				end
				O_PA: begin
					pb_next[wch] = avs_req.writedata;
					pc_next[wch] = avs_req.writedata; // RULE_06
				end
				O_MA: begin
					mb_next[wch] = avs_req.writedata;
					mc_next[wch] = avs_req.writedata;
				end
				default: ;
			endcase
		end
		for (int i = 0; i < NCH; i++) begin
			irq_next[i] = |(fl_next[i] & {ctl_next[i][C_EIE],
				ctl_next[i][C_HIE], ctl_next[i][C_FIE]}); // RULE_09
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Slave answers every access on its second cycle.
	always_comb begin
		ack_next = (avs_req.read || avs_req.write) && !ack_reg;
		avs_next = '{readdata: 32'h0, waitrequest: !ack_next};
		if (ack_next && avs_req.read) begin
			if (avs_req.address == A_INTF) begin
				for (int i = 0; i < NCH; i++) begin
					avs_next.readdata[4*i +: 4] =
						{fl_reg[i][F_ER], fl_reg[i][F_HT], fl_reg[i][F_FT],
						|fl_reg[i]};
				end
			end else if (ch_hit) begin
				unique case (avs_req.address[3:0])
					O_CTL: avs_next.readdata = ctl_reg[wch];
					O_CNT: avs_next.readdata = 32'(cnt_reg[wch]);
					O_PA: avs_next.readdata = pb_reg[wch];
					O_MA: avs_next.readdata = mb_reg[wch];
					default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NCH; i++) begin
				ctl_reg[i] <= RST_CTL;
				cnt_reg[i] <= RST_CNT;
				rld_reg[i] <= RST_CNT;
				pb_reg[i]  <= RST_ADDR;
				mb_reg[i]  <= RST_ADDR;
				pc_reg[i]  <= RST_ADDR;
				mc_reg[i]  <= RST_ADDR;
				fl_reg[i]  <= 3'h0;
			end
			st_reg   <= ST_IDLE;
			sel_reg  <= 3'h0;
			ack_reg  <= 1'b0;
			avs_reg  <= '{readdata: 32'h0, waitrequest: 1'b1};
			mreq_reg <= '0;
			preq_reg <= '0;
			dack_reg <= '0;
			irq_reg  <= '0;
		end else begin
			ctl_reg  <= ctl_next;
			cnt_reg  <= cnt_next;
			rld_reg  <= rld_next;
			pb_reg   <= pb_next;
			mb_reg   <= mb_next;
			pc_reg   <= pc_next;
			mc_reg   <= mc_next;
			fl_reg   <= fl_next;
			st_reg   <= st_next;
			sel_reg  <= sel_next;
			ack_reg  <= ack_next;
			avs_reg  <= avs_next;
			mreq_reg <= mreq_next;
			preq_reg <= preq_next;
			dack_reg <= dack_next;
			irq_reg  <= irq_next;
		end
	end

	assign avs_rsp = avs_reg;
	assign mem_req = mreq_reg;
	assign per_req = preq_reg;
	assign dack    = dack_reg;
	assign irq     = irq_reg;

	////////////////////////////////////////////////////////////////////////
	logic [CW-1:0] s_cnt, s_rld;
	logic [31:0]   s_mc, s_mstep;
	logic [NCH-1:0] irq_chk;
	assign s_cnt   = cnt_reg[sel_reg];
	assign s_rld   = rld_reg[sel_reg];
	assign s_mc    = mc_reg[sel_reg];
	assign s_mstep = sz_bytes(ctl_reg[sel_reg][C_MSZ +: 2]);
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			irq_chk[i] = |(fl_reg[i] & {ctl_reg[i][C_EIE],
				ctl_reg[i][C_HIE], ctl_reg[i][C_FIE]});
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_rd_done;
		rd_ok && rsp_rd.response == RESP_OK;
	endsequence
	sequence s_wr_issued;
		st_reg == ST_WR && (mreq_reg.write || preq_reg.write);
	endsequence
	property p_rd_wr;
		s_rd_done |=> s_wr_issued;
	endproperty
	a_rd_wr: assert property (p_rd_wr) // RULE_14
		else $error("write did not follow accepted read");
	property p_one_access;
		!((mreq_reg.read || mreq_reg.write) &&
		(preq_reg.read || preq_reg.write)) &&
		!(mreq_reg.read && mreq_reg.write);
	endproperty
	a_one_access: assert property (p_one_access) // RULE_24
		else $error("two bus accesses at once");
	property p_grant;
		(st_reg == ST_IDLE && any_el) |=>
		st_reg == ST_RD && (mreq_reg.read || preq_reg.read);
	endproperty
	a_grant: assert property (p_grant) // RULE_11
		else $error("pending channel not granted");
	property p_cnt;
		(wr_ok && !sw_wr) |=> (s_cnt == $past(s_cnt) - 17'h1) ||
		($past(ctl_reg[sel_reg][C_CIRC]) && s_cnt == s_rld);
	endproperty
	a_cnt: assert property (p_cnt) // RULE_15
		else $error("item count not stepped");
	property p_minc;
		(wr_ok && !sw_wr && ctl_reg[sel_reg][C_MINC] &&
		s_cnt != 17'h1) |=> s_mc == $past(s_mc) + $past(s_mstep);
	endproperty
	a_minc: assert property (p_minc) // RULE_23
		else $error("memory address not stepped by size");
	property p_dack;
		|dack_reg |-> $onehot(dack_reg) &&
		(preq_reg.read || preq_reg.write) && st_reg != ST_IDLE;
	endproperty
	a_dack: assert property (p_dack) // RULE_20
		else $error("acknowledge without peripheral access");
	property p_irq;
		irq_reg == irq_chk;
	endproperty
	a_irq: assert property (p_irq) // RULE_09
		else $error("interrupt disagrees with flags");
	property p_stop;
		(st_reg == ST_IDLE && s_cnt == RST_CNT && sel_reg == win &&
		!any_el) |=> st_reg == ST_IDLE;
	endproperty
	a_stop: assert property (p_stop) // RULE_22
		else $error("channel ran with zero count");
endmodule // mcdma_core

////////////////////////////////////////////////////////////////////////////
module mcdma_top (
	input  wire logic                      clk,
	input  wire logic                      nrst,
	input  wire mcdma_pkg::mcdma_avs_req_t avs_a_req,
	output mcdma_pkg::mcdma_avs_rsp_t      avs_a_rsp,
	output mcdma_pkg::mcdma_avm_req_t      mem_a_req,
	input  wire mcdma_pkg::mcdma_avm_rsp_t mem_a_rsp,
	output mcdma_pkg::mcdma_avm_req_t      per_a_req,
	input  wire mcdma_pkg::mcdma_avm_rsp_t per_a_rsp,
	input  wire logic [13:0]               dreq_a,
	output logic [13:0]                    dack_a,
	output logic [6:0]                     irq_a,
	input  wire mcdma_pkg::mcdma_avs_req_t avs_b_req,
	output mcdma_pkg::mcdma_avs_rsp_t      avs_b_rsp,
	output mcdma_pkg::mcdma_avm_req_t      mem_b_req,
	input  wire mcdma_pkg::mcdma_avm_rsp_t mem_b_rsp,
	output mcdma_pkg::mcdma_avm_req_t      per_b_req,
	input  wire mcdma_pkg::mcdma_avm_rsp_t per_b_rsp,
	input  wire logic [9:0]                dreq_b,
	output logic [9:0]                     dack_b,
	output logic [4:0]                     irq_b
);
	import mcdma_pkg::*;
	logic [1:0] rs_reg;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rs_reg <= 2'b00;
		end else begin
			rs_reg <= {rs_reg[0], 1'b1};
		end
	end
	mcdma_core #(.NCH(CH_A)) controller_inst_a ( // RULE_01
		.clk(clk), .rst_n(rs_reg[1]),
		.avs_req(avs_a_req), .avs_rsp(avs_a_rsp),
		.mem_req(mem_a_req), .mem_rsp(mem_a_rsp),
		.per_req(per_a_req), .per_rsp(per_a_rsp),
		.dreq(dreq_a), .dack(dack_a), .irq(irq_a));
	mcdma_core #(.NCH(CH_B)) controller_inst_b (
		.clk(clk), .rst_n(rs_reg[1]),
		.avs_req(avs_b_req), .avs_rsp(avs_b_rsp),
		.mem_req(mem_b_req), .mem_rsp(mem_b_rsp),
		.per_req(per_b_req), .per_rsp(per_b_rsp),
		.dreq(dreq_b), .dack(dack_b), .irq(irq_b));
endmodule // mcdma_top

/* File: testbench.sv */
// Self-checking bench for both controller instances.
// Assumes four slave models on the master ports and dreq driven here.
`timescale 1ns/100ps

module testbench;
	import mcdma_pkg::*;
	logic           clk = 1'b0;
	logic           nrst = 1'b0;
	mcdma_avs_req_t avs_req [2];
	mcdma_avs_rsp_t avs_rsp [2];
	mcdma_avm_req_t mreq [2];
	mcdma_avm_rsp_t mrsp [2];
	mcdma_avm_req_t preq [2];
	mcdma_avm_rsp_t prsp [2];
	logic [13:0]    dreq_a = '0;
	logic [13:0]    dreq_raise = '0;
	logic [13:0]    dack_a;
	logic [9:0]     dreq_b = '0;
	logic [9:0]     dack_b;
	logic [6:0]     irq_a;
	logic [4:0]     irq_b;
	logic [68:0]    wq [$];
	logic [68:0]    ew [$];
	logic [31:0]    pq [$];
	int             mismatches = 0;
	int             compares = 0;
	int             dack_cnt = 0;
	always #50 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	mcdma_top i_mcdma_top (
		.clk(clk), .nrst(nrst),
		.avs_a_req(avs_req[0]), .avs_a_rsp(avs_rsp[0]),
		.mem_a_req(mreq[0]), .mem_a_rsp(mrsp[0]),
		.per_a_req(preq[0]), .per_a_rsp(prsp[0]),
		.dreq_a(dreq_a), .dack_a(dack_a), .irq_a(irq_a),
		.avs_b_req(avs_req[1]), .avs_b_rsp(avs_rsp[1]),
		.mem_b_req(mreq[1]), .mem_b_rsp(mrsp[1]),
		.per_b_req(preq[1]), .per_b_rsp(prsp[1]),
		.dreq_b(dreq_b), .dack_b(dack_b), .irq_b(irq_b)
	);
	for (genvar g = 0; g < 2; g++) begin : g_mem
		mcdma_avm_model i_mcdma_avm_model (.clk(clk), .req(mreq[g]),
			.rsp(mrsp[g]));
	end
	for (genvar g = 0; g < 2; g++) begin : g_per
		mcdma_avm_model i_mcdma_avm_model (.clk(clk), .req(preq[g]),
			.rsp(prsp[g]));
	end
	////////////////////////////////////////////////////////////////////////
	// The peripheral drops its request on the edge after the acknowledge.
	always @(posedge clk) begin
		dreq_a <= (dreq_a & ~dack_a) | dreq_raise;
	end
	always @(negedge clk) begin
		for (int s = 0; s < 2; s++) begin
			if (mreq[s].write && !mrsp[s].waitrequest)
				wq.push_back({s[0], mreq[s].address, mreq[s].writedata,
					mreq[s].byteenable});
			if (preq[s].write && !prsp[s].waitrequest)
				wq.push_back({s[0], preq[s].address, preq[s].writedata,
					preq[s].byteenable});
		end
		if (preq[0].read && !prsp[0].waitrequest)
			pq.push_back(preq[0].address);
		dack_cnt += $countones(dack_a);
	end
	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [68:0] seen, input logic [68:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic bus(input int s, input logic w, input logic [10:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		avs_req[s] <= '{!w, w, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (avs_rsp[s].waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			mismatches++;
			stop_test();
		end
		q = avs_rsp[s].readdata;
		avs_req[s] <= '{1'b0, 1'b0, a, d};
	endtask
	task automatic wr(input int s, input logic [10:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(s, 1'b1, a, d, q);
	endtask
	function automatic logic [10:0] ca(input int ch, input logic [3:0] o);
		return {7'(CH_BLK0 + 7'(ch)), o};
	endfunction
	function automatic logic [31:0] mask(input int b);
		return (b == 4) ? 32'hffff_ffff : ((32'h1 << (8 * b)) - 32'h1);
	endfunction
	function automatic logic [31:0] ctl(input int ps, ms, pr, m2m, circ, pi,
		mi);
		logic [31:0] c;
		c = 32'h0;
		c[C_EN] = 1'b1;
		c[C_FIE] = 1'b1;
		c[C_EIE] = 1'b1;
		c[C_CIRC] = circ[0];
		c[C_PINC] = pi[0];
		c[C_MINC] = mi[0];
		c[C_M2M] = m2m[0];
		c[C_PSZ +: 2] = 2'(ps);
		c[C_MSZ +: 2] = 2'(ms);
		c[C_PRIO +: 2] = 2'(pr);
		return c;
	endfunction
	task automatic prog(input int s, ch, input logic [31:0] pb, mb, cnt, c);
		wr(s, ca(ch, O_CTL), 32'h0);
		wr(s, ca(ch, O_PA), pb);
		wr(s, ca(ch, O_MA), mb);
		wr(s, ca(ch, O_CNT), cnt);
		wr(s, ca(ch, O_CTL), c);
	endtask
	// Items wrap every per items, which models the circular reload.
	task automatic expect_items(input int s, n, per, input logic [31:0] pb,
		mb, input int ps, ms, pi, mi);
		logic [31:0] sa, da, it;
		int          sb, db;
		sb = 1 << ps;
		db = 1 << ms;
		for (int i = 0; i < n; i++) begin
			sa = pb + 32'(pi * (i % per) * sb);
			da = mb + 32'(mi * (i % per) * db);
			it = ((sa & ~32'h3) ^ 32'h5a3c_96e1) >> (8 * sa[1:0]);
			it = it & mask(sb) & mask(db);
			ew.push_back({s[0], da & ~32'h3, it << (8 * da[1:0]),
				4'((1 << db) - 1) << da[1:0]});
		end
	endtask
	task automatic drain(input int n);
		int k;
		k = 0;
		while (wq.size() < n && k < 3000) begin
			@(posedge clk);
			k++;
		end
		if (k >= 3000) begin
			mismatches++;
			stop_test();
		end
		repeat (n) check(wq.pop_front(), ew.pop_front());
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge clk);
		mismatches++;
		stop_test();
	end
	initial begin
		logic [31:0] q, pb, mb;
		int          ps, ms, w;
		void'($urandom(4));
		avs_req[0] = '0;
		avs_req[1] = '0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		bus(0, 1'b0, ca(0, O_CTL), 32'h0, q);
		check(q, RST_CTL);
		wr(0, 11'h7fc, 32'hffff_ffff);
		bus(0, 1'b0, 11'h7fc, 32'h0, q);
		check(q, 32'h0);
		wr(0, ca(6, O_CNT), 32'h0001_ffff);
		bus(0, 1'b0, ca(6, O_CNT), 32'h0, q);
		check(q, 32'(CNT_MAX));
		for (int k = 0; k < 9; k++) begin
			ps = k / 3;
			ms = k % 3;
			pb = 32'h1000_0000 | ($urandom & 32'hfff0);
			mb = 32'h2000_0000 | ($urandom & 32'hfff0);
			expect_items(0, 4, 4, pb, mb, ps, ms, ps != 1, ms != 0);
			prog(0, 0, pb, mb, 4, ctl(ps, ms, 0, 1, 0, ps != 1, ms != 0));
			drain(4);
			bus(0, 1'b0, ca(0, O_CNT), 32'h0, q);
			check(q, 32'h0);
		end
		bus(0, 1'b0, A_INTF, 32'h0, q);
		check({q[1], irq_a[0]}, 2'b11);
		wr(0, A_INTC, 32'h1);
		bus(0, 1'b0, A_INTF, 32'h0, q);
		check({q[3:0], irq_a[0]}, 5'h0);
		for (int k = 0; k < 3; k++) begin
			w = (k == 0) ? 5 : 3;
			prog(0, 3, 32'h4000_0300, 32'h2000_0300, 1,
				ctl(2, 2, k + 1, 0, 0, 1, 1));
			prog(0, 5, 32'h4000_0500, 32'h2000_0500, 1,
				ctl(2, 2, 2 - 2 * (k / 2), 0, 0, 1, 1));
			expect_items(0, 1, 1, 32'h4000_0000 + 32'(w * 256),
				32'h2000_0000 + 32'(w * 256), 2, 2, 1, 1);
			expect_items(0, 1, 1, 32'h4000_0000 + 32'((8 - w) * 256),
				32'h2000_0000 + 32'((8 - w) * 256), 2, 2, 1, 1);
			@(posedge clk);
			dreq_raise <= 14'h0840;
			@(posedge clk);
			dreq_raise <= 14'h0;
			drain(2);
			check(pq.pop_front(), 32'h4000_0000 + 32'(w * 256));
			pq.delete();
		end
		check(dack_cnt, 6);
		expect_items(0, 2, 2, 32'h2000_0202, 32'h4000_0200, 1, 2, 1, 0);
		prog(0, 2, 32'h4000_0200, 32'h2000_0202, 2,
			ctl(2, 1, 0, 0, 0, 0, 1) | (32'h1 << C_DIR));
		dreq_raise <= 14'h0010;
		drain(2);
		dreq_raise <= 14'h0;
		prog(0, 1, 32'hf000_0000, 32'h2000_0100, 2, ctl(2, 2, 0, 1, 0, 1, 1));
		q = 32'h0;
		for (int n = 0; n < 50 && q[7] !== 1'b1; n++)
			bus(0, 1'b0, A_INTF, 32'h0, q);
		check({q[7:4], irq_a[1], wq.size() == 0}, 6'b1001_1_1);
		bus(0, 1'b0, ca(1, O_CTL), 32'h0, q);
		check(q[C_EN], 1'b0);
		wr(0, A_INTC, 32'h10);
		bus(0, 1'b0, A_INTF, 32'h0, q);
		check({q[7:4], irq_a[1]}, 5'h0);
		expect_items(1, 5, 2, 32'h3000_0000, 32'h2000_0800, 1, 0, 1, 1);
		prog(1, 4, 32'h3000_0000, 32'h2000_0800, 2, ctl(1, 0, 3, 1, 1, 1, 1));
		drain(5);
		check(irq_b[4], 1'b1);
		wr(1, ca(4, O_CTL), 32'h0);
		bus(1, 1'b0, ca(4, O_CNT), 32'h0, q);
		check(q != 32'h0, 1'b1);
		stop_test();
	end
endmodule // testbench
